// File: shared/video_display_overlay_consts.vh
`ifndef VIDEO_DISPLAY_OVERLAY_CONSTS_VH
`define VIDEO_DISPLAY_OVERLAY_CONSTS_VH

// register byte offsets
`define OFS_DISP_CFG        12'h018
`define OFS_MASK_UPPER      12'h01C
`define OFS_MASK_LOWER      12'h020
`define OFS_OVERLAY_CTRL    12'h024

// display configuration fields
`define DCFG_EN_BIT         31
`define DCFG_THR_HI         30
`define DCFG_THR_LO         24
`define DCFG_BRIDGE_BIT     24
`define DCFG_HT_HI          21
`define DCFG_HT_LO          12
`define DCFG_WID_HI         9
`define DCFG_WID_LO         0
`define DCFG_WMASK          32'hFF3FF3FF

// overlay control fields
`define OVL_EN_BIT          15
`define OVL_GAP_HI          7
`define OVL_GAP_LO          0
`define OVL_WMASK           32'h000080FF

// mask base writable bits
`define MASK_BASE_WMASK     32'hFFFFFFFC

// reset values
`define RST_DISP_CFG        32'h0F0F03FF
`define RST_MASK_BASE       32'h0FFFFFFC
`define RST_OVERLAY_CTRL    32'h000000FF

`endif

// File: hdl/video_display_overlay_config.v
// Overview of operation
// [R1] display enable low blocks all video write DMA; resets to zero.
// [R2] request a write burst when FIFO doublewords reach threshold; default 0x0F.
// [R3] threshold LSB is also the bridge-type bit, limiting its parity.
// [R4] bridge-type bit changes request assert and release; one is generic.
// [R5] window height counts half lines in mode zero, all in mode one.
// [R6] window width in pixels, bits 9:0, resets to 0x3FF.
// [R7] upper field mask base at 0x01C, low bits read zero, reset 0xFFFFFFC.
// [R8] lower field mask base at 0x020, low bits hardwired zero.
// [R9] overlay enable makes mask data decide visibility; else video on top.
// [R10] mask stride in doublewords added after each mask line end.
// [R11] software sets stride zero or line length for contiguous mask lines; here only stride zero makes them contiguous.
// [R12] reserved bits of both config registers read back as zero.
// [R13] mask reads start at field-matching base then advance by stride.
// [R14] clearing enable mid-transaction lets the current transaction finish.
`timescale 1ns/1ps
`default_nettype none
`include "video_display_overlay_consts.vh"

module video_display_overlay_config (
    input  wire        clk,
    input  wire        arst_n,
    // register access port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [3:0]  reg_be,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    output reg         reg_ack,
    // video write DMA side
    input  wire [6:0]  fifo_level,
    input  wire        xact_active,
    output reg         burst_req,
    input  wire        vin_valid,
    output wire        vin_ready,
    input  wire [31:0] vin_data,
    output wire        vout_valid,
    input  wire        vout_ready,
    output wire [31:0] vout_data,
    // window geometry
    input  wire        line_interleave_select,
    output wire [10:0] display_line_total,
    output wire [9:0]  window_pixel_width,
    output wire        bridge_generic,
    // mask read DMA
    input  wire        field_start,
    input  wire        field_is_lower,
    input  wire        mask_dword_done,
    input  wire        mask_line_done,
    output reg  [31:0] mask_read_addr,
    output wire        mask_read_enable,
    input  wire        mask_bit,
    output wire        video_visible
);

    reg  [31:0] disp_cfg_q;
    reg  [31:0] upper_q;
    reg  [31:0] lower_q;
    reg  [31:0] ovl_q;
    reg  [31:0] rd_mux;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        input [31:0] wmask;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
            merge = merge & wmask;
        end
    endfunction

    // one-hot register select, shared by the write and read paths
    function [3:0] reg_select;
        input [11:0] addr;
        begin
            case (addr)
                `OFS_DISP_CFG: begin
                    reg_select = 4'h1;
                end
                `OFS_MASK_UPPER: begin
                    reg_select = 4'h2;
                end
                `OFS_MASK_LOWER: begin
                    reg_select = 4'h4;
                end
                `OFS_OVERLAY_CTRL: begin
                    reg_select = 4'h8;
                end
                default: begin
                    reg_select = 4'h0;
                end
            endcase
        end
    endfunction

    // advance a byte address by a count of doublewords
    function [31:0] dword_step;
        input [31:0] addr;
        input [8:0]  dwords;
        begin
            dword_step = addr + {21'h000000, dwords, 2'h0};
        end
    endfunction

    // unmapped offsets select nothing: writes vanish, reads give zero
    wire [3:0] wr_sel = reg_wr ? reg_select(reg_addr) : 4'h0;
    wire [3:0] rd_sel = reg_select(reg_addr);

    // write masks keep reserved bits and base bits 1:0 at zero
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            disp_cfg_q <= `RST_DISP_CFG; // see [R1]
            upper_q    <= `RST_MASK_BASE;
            lower_q    <= `RST_MASK_BASE;
            ovl_q      <= `RST_OVERLAY_CTRL;
        end else begin
            if (wr_sel[0]) begin
                // one shared flop for threshold LSB and bridge type
                disp_cfg_q <= merge(disp_cfg_q, reg_wdata, reg_be,
                                    `DCFG_WMASK); // see [R3] see [R12]
            end
            if (wr_sel[1]) begin
                upper_q <= merge(upper_q, reg_wdata, reg_be,
                                 `MASK_BASE_WMASK); // see [R7]
            end
            if (wr_sel[2]) begin
                lower_q <= merge(lower_q, reg_wdata, reg_be,
                                 `MASK_BASE_WMASK); // see [R8]
            end
            if (wr_sel[3]) begin
                ovl_q <= merge(ovl_q, reg_wdata, reg_be,
                               `OVL_WMASK); // see [R12]
            end
        end
    end

    always @* begin
        rd_mux = 32'h00000000;
        if (rd_sel[0]) begin
            rd_mux = disp_cfg_q;
        end
        if (rd_sel[1]) begin
            rd_mux = upper_q;
        end
        if (rd_sel[2]) begin
            rd_mux = lower_q;
        end
        if (rd_sel[3]) begin
            rd_mux = ovl_q;
        end
    end

    // acknowledge every access one cycle after its strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_ack <= 1'h0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
        end
    end

    // read data is zero outside the acknowledge cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    wire       vid_en    = disp_cfg_q[`DCFG_EN_BIT];
    wire [6:0] threshold = disp_cfg_q[`DCFG_THR_HI:`DCFG_THR_LO];
    wire       hit       = fifo_level >= threshold; // see [R2]

    assign bridge_generic = disp_cfg_q[`DCFG_BRIDGE_BIT];

    // generic bridge holds request while level stays high; special bridge
    // drops it during a transaction and re-raises it afterwards
    reg         burst_req_d;
    always @* begin
        burst_req_d = 1'h0; // see [R1]
        if (vid_en) begin
            if (bridge_generic) begin
                burst_req_d = hit; // see [R4]
            end else begin
                burst_req_d = hit & ~xact_active; // see [R4]
            end
        end
    end

    // registered so the request never glitches on the bus
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_req <= 1'h0;
        end else begin
            burst_req <= burst_req_d;
        end
    end

    // two-entry buffer; an ongoing transaction drains even if disabled
    reg  [31:0] buf_mem [0:1];
    reg         wr_ptr_q;
    reg         rd_ptr_q;
    reg  [1:0]  cnt_q;
    wire        pass_en = vid_en | xact_active; // see [R14]
    wire        push    = vin_valid & vin_ready;
    wire        pop     = vout_valid & vout_ready;

    assign vin_ready  = (cnt_q != 2'd2) & pass_en; // see [R1]
    assign vout_valid = (cnt_q != 2'd0) & pass_en; // see [R14]
    assign vout_data  = buf_mem[rd_ptr_q];

    // occupancy: push and pop together leave it unchanged
    reg  [1:0]  cnt_d;
    always @* begin
        case ({push, pop})
            2'h2: begin
                cnt_d = cnt_q + 2'h1;
            end
            2'h1: begin
                cnt_d = cnt_q - 2'h1;
            end
            default: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_mem[0] <= 32'h00000000;
            buf_mem[1] <= 32'h00000000;
            wr_ptr_q   <= 1'h0;
            rd_ptr_q   <= 1'h0;
            cnt_q      <= 2'h0;
        end else begin
            if (push) begin
                buf_mem[wr_ptr_q] <= vin_data;
                wr_ptr_q          <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_d;
        end
    end

    wire [9:0] ht = disp_cfg_q[`DCFG_HT_HI:`DCFG_HT_LO];
    assign display_line_total = line_interleave_select ?
                                {1'b0, ht} : {ht, 1'b0}; // see [R5]
    assign window_pixel_width =
        disp_cfg_q[`DCFG_WID_HI:`DCFG_WID_LO]; // see [R6]

    wire       ovl_en = ovl_q[`OVL_EN_BIT];
    wire [7:0] gap    = ovl_q[`OVL_GAP_HI:`OVL_GAP_LO];

    assign mask_read_enable = ovl_en;
    assign video_visible    = ~ovl_en | mask_bit; // see [R9]

    // address holds while overlay is off, so a later enable resumes cleanly
    reg  [31:0] mask_addr_d;
    always @* begin
        mask_addr_d = mask_read_addr;
        if (ovl_en) begin
            if (field_start) begin
                mask_addr_d = field_is_lower ? lower_q
                                             : upper_q; // see [R13]
            end else if (mask_line_done) begin
                // last dword of the line counts, then the gap in dwords
                mask_addr_d = dword_step(mask_read_addr,
                                         {1'h0, gap} + 9'h001); // see [R10]
            end else if (mask_dword_done) begin
                mask_addr_d = dword_step(mask_read_addr, 9'h001);
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_read_addr <= 32'h00000000;
        end else begin
            mask_read_addr <= mask_addr_d;
        end
    end

endmodule

`default_nettype wire

// File: tb/overlay_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module overlay_cfg_asserts (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_ack,
    input wire logic [31:0] reg_rdata,
    input wire logic [6:0]  fifo_level,
    input wire logic        xact_active,
    input wire logic        burst_req,
    input wire logic        bridge_generic,
    input wire logic        mask_read_enable,
    input wire logic [31:0] mask_read_addr,
    input wire logic        mask_bit,
    input wire logic        video_visible
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ack_follows_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("access not acked");
    ack_idle_a: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
        else $error("stray ack");
    rdata_quiet_a: assert property (!reg_ack |-> reg_rdata == 32'h0)
        else $error("read data outside ack");
    empty_no_req_a: assert property (fifo_level == 7'h0
        |=> !burst_req) else $error("request with empty fifo");
    special_drop_a: assert property (!bridge_generic && xact_active
        |=> !burst_req) else $error("request during transaction");
    visible_rule_a: assert property (video_visible ==
        (!mask_read_enable || mask_bit)) else $error("visibility wrong");
    addr_hold_a: assert property (!mask_read_enable
        |=> $stable(mask_read_addr)) else $error("mask address moved");
    addr_align_a: assert property (mask_read_addr[1:0] == 2'h0)
        else $error("mask address unaligned");
endmodule
`default_nettype wire

// File: tb/host_sink.sv
`timescale 1ns/1ps
`default_nettype none
module host_sink (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        stall,
    input  wire logic        vout_valid,
    input  wire logic [31:0] vout_data,
    output logic             vout_ready,
    output logic [95:0]      seen
);
    // memory side back-pressure: stall holds off the drain
    assign vout_ready = !stall;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            seen <= '0;
        else if (vout_valid && vout_ready)
            seen <= {seen[63:0], vout_data};
    end
endmodule
`default_nettype wire

// File: tb/tb_video_display_overlay_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_video_display_overlay_config;
    logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, stall = 1;
    logic        xact_active = 0, vin_valid = 0, line_interleave_select = 0;
    logic        field_start = 0, field_is_lower = 0, mask_dword_done = 0;
    logic        mask_line_done = 0, mask_bit = 0, reg_ack, burst_req;
    logic        vin_ready, vout_valid, vout_ready, bridge_generic;
    logic        mask_read_enable, video_visible;
    logic [6:0]  fifo_level = 0;
    logic [3:0]  reg_be = 4'hF;
    logic [11:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, vin_data = 0, reg_rdata, vout_data;
    logic [31:0] mask_read_addr;
    logic [10:0] display_line_total;
    logic [9:0]  window_pixel_width;
    logic [95:0] seen;
    int          fail_count = 0, comparisons = 0;
    always #50 clk = ~clk;
    video_display_overlay_config u_dut (.clk, .arst_n, .reg_wr, .reg_rd,
        .reg_addr, .reg_be, .reg_wdata, .reg_rdata, .reg_ack,
        .fifo_level, .xact_active, .burst_req, .vin_valid, .vin_ready,
        .vin_data, .vout_valid, .vout_ready, .vout_data,
        .line_interleave_select, .display_line_total, .window_pixel_width,
        .bridge_generic, .field_start, .field_is_lower, .mask_dword_done,
        .mask_line_done, .mask_read_addr, .mask_read_enable, .mask_bit,
        .video_visible);
    host_sink u_host (.clk, .arst_n, .stall, .vout_valid, .vout_data,
        .vout_ready, .seen);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk) reg_wr <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk) reg_rd <= 0;
        #1 chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic ev(input logic [3:0] k, input logic [31:0] e);
        {field_is_lower, field_start, mask_line_done, mask_dword_done} <= k;
        @(posedge clk) {field_start, mask_line_done, mask_dword_done} <= 0;
        #1 chk(mask_read_addr, e);
        @(posedge clk);
    endtask
    task automatic t_regs;
        rd(12'h018, 32'h0F0F03FF);
        rd(12'h01C, 32'h0FFFFFFC);
        rd(12'h024, 32'h000000FF);
        rd(12'h028, 32'h0);
        wr(12'h018, '1);
        rd(12'h018, 32'hFF3FF3FF);
        wr(12'h020, '1);
        rd(12'h020, 32'hFFFFFFFC);
        line_interleave_select <= 1;
        #1 chk(32'(display_line_total), 32'h3FF);
        chk(32'(window_pixel_width), 32'h3FF);
        @(posedge clk) line_interleave_select <= 0;
        #1 chk(32'(display_line_total), 32'h7FE);
        @(posedge clk);
    endtask
    task automatic t_burst;
        wr(12'h018, 32'h85000000);
        fifo_level <= 7'h4;
        settle;
        chk(burst_req, 0);
        @(posedge clk) fifo_level <= 7'h5;
        settle;
        chk(burst_req, 1);
        @(posedge clk);
        wr(12'h018, 32'h05000000);
        settle;
        chk(burst_req, 0);
        @(posedge clk);
        wr(12'h018, 32'h84000000);
        xact_active <= 1;
        settle;
        chk(burst_req, 0);
        chk(bridge_generic, 0);
        @(posedge clk) xact_active <= 0;
        settle;
        chk(burst_req, 1);
        @(posedge clk);
    endtask
    task automatic t_mask;
        wr(12'h01C, 32'h1000);
        wr(12'h020, 32'h2000);
        wr(12'h024, 32'hFFFF8003);
        rd(12'h024, 32'h8003);
        chk(mask_read_enable, 1);
        chk(video_visible, 0);
        ev(4'h4, 32'h1000);
        ev(4'h1, 32'h1004);
        ev(4'h2, 32'h1014);
        ev(4'hC, 32'h2000);
        reg_be <= 4'h2;
        wr(12'h024, 32'h0);
        reg_be <= 4'hF;
        rd(12'h024, 32'h3);
        chk(video_visible, 1);
        ev(4'h1, 32'h2000);
    endtask
    task automatic t_gate;
        wr(12'h018, 32'h04000000);
        #1 chk(vin_ready, 0);
        @(posedge clk) xact_active <= 1;
        #1 chk(vin_ready, 1);
        @(posedge clk) xact_active <= 0;
        #1 chk(vin_ready, 0);
        @(posedge clk);
    endtask
    task automatic t_buf;
        vin_valid <= 1;
        vin_data <= 32'hA1;
        @(posedge clk) vin_data <= 32'hB2;
        @(posedge clk) vin_data <= 32'hC3;
        settle;
        chk(vin_ready, 0);
        chk(vout_data, 32'hA1);
        @(posedge clk) stall <= 0;
        @(negedge clk);
        while (!vin_ready) @(negedge clk);
        @(posedge clk) vin_valid <= 0;
        settle;
        settle;
        chk(seen[95:64], 32'hA1);
        chk(seen[63:32], 32'hB2);
        chk(seen[31:0], 32'hC3);
    endtask
    task automatic results;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        t_regs;
        t_burst;
        t_mask;
        t_buf;
        t_gate;
        results;
    end
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        results;
    end
endmodule
bind video_display_overlay_config overlay_cfg_asserts u_chk (.clk, .arst_n,
    .reg_wr, .reg_rd, .reg_ack, .reg_rdata, .fifo_level, .xact_active,
    .burst_req, .bridge_generic, .mask_read_enable, .mask_read_addr,
    .mask_bit, .video_visible);
`default_nettype wire
